// >>> logic/adc_result_fmt.sv
// result formatting, sign check and calibration read for the converter
// How it works
// - result bytes hold the result once the done flag is high
// - single-ended code is the unsigned core code, 0x000 to 0x3FF
// - unipolar differential saturates negative differences to zero
// - differential gain is 8x or 20x from the channel-select low bit
// - unipolar by default; bipolar only while bipolar select is set
// - bipolar result is two's complement 0x200 to 0x1FF
// - sign of bipolar result sits in the top result bit
// - signature row holds unsigned gain (1/128) and signed offset
// - result bytes and done flag update in the same cycle
// - left-adjust change shows on the result bytes one clock edge later
`include "adc_fmt_cfg.svh"
module adc_result_fmt (
    input  wire logic                       clk_in,                // 25 MHz system clock
    input  wire logic                       rstn_in,               // sync reset, active low
    input  wire adc_fmt_pkg::core_result_t  core_in,               // converter core result
    input  wire logic [4:0]                 channel_select_field_in, // channel and gain code
    input  wire logic                       bipolar_input_select_in, // bipolar mode bit
    input  wire logic                       left_adjust_select_in, // left adjust bit
    input  wire logic                       done_clear_in,         // software clears done flag
    input  wire logic                       sig_read_in,           // signature byte request
    input  wire logic [2:0]                 sig_addr_in,           // signature byte address
    output logic [7:0]                      result_low_byte_out,   // low result byte
    output logic [7:0]                      result_high_byte_out,  // high result byte
    output logic                            conversion_done_flag_out, // conversion done
    output logic                            result_sign_bit_out,   // top result bit
    output logic [4:0]                      gain_out,              // applied gain factor
    output logic [1:0]                      mode_out,              // conversion form in use
    output logic [7:0]                      sig_data_out,          // signature byte
    output logic                            sig_valid_out          // signature byte ready
);

    // ==========================================================
    // format selection
    adc_fmt_pkg::conv_mode_t mode;       // form picked from channel and bipolar bit
    logic                    is_diff;    // differential pair selected
    logic                    gain_high;  // 20x pair rather than 8x
    logic [9:0]              next_code;  // formatted code of the arriving result

    // channel code splits into the differential flag and the gain pick
    assign is_diff   = channel_select_field_in[`DIFF_BIT];
    assign gain_high = channel_select_field_in[`GAIN_SEL_BIT];

    // mode select bit
    // bipolar is honoured only on differential pairs; single-ended ignores it
    always_comb begin
        if (!is_diff) begin
            mode = adc_fmt_pkg::SINGLE;
        end else if (bipolar_input_select_in) begin
            mode = adc_fmt_pkg::BIPOLAR;
        end else begin
            mode = adc_fmt_pkg::UNIPOLAR;
        end
    end

    // form the code for each conversion type
    // the core already hands over a two's complement word for bipolar pairs,
    // so only the unipolar form needs extra work here
    always_comb begin
        next_code = core_in.diff;
        case (mode)
            adc_fmt_pkg::SINGLE: begin
                next_code = core_in.diff;
            end
            adc_fmt_pkg::UNIPOLAR: begin
                if (core_in.neg) begin
                    next_code = `CODE_ZERO;
                end else begin
                    next_code = core_in.diff;
                end
            end
            adc_fmt_pkg::BIPOLAR: begin
                next_code = core_in.diff;
            end
            default: begin
                next_code = core_in.diff;
            end
        endcase
    end

    // ==========================================================
    // result capture and done flag
    logic [9:0] code;  // last captured result

    // same-cycle update
    // capture and flag share the valid strobe, so software never sees one
    // without the other
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            code <= `CODE_ZERO;
        end else if (core_in.valid) begin
            code <= next_code;
        end
    end

    // done flag marks result ready
    // set wins over a clear in the same cycle, so a fresh result is never
    // hidden by a late clear of the previous one
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            conversion_done_flag_out <= 1'b0;
        end else if (core_in.valid) begin
            conversion_done_flag_out <= 1'b1;
        end else if (done_clear_in) begin
            conversion_done_flag_out <= 1'b0;
        end
    end

    // ==========================================================
    // byte presentation
    logic [9:0]  shown;      // result on its way to the byte pair
    logic [15:0] right_img;  // byte pair, right adjusted
    logic [15:0] left_img;   // byte pair, left adjusted

    // a result arriving this cycle bypasses the capture register so the
    // bytes and the done flag land on the same edge
    assign shown     = core_in.valid ? next_code : code;
    assign right_img = {6'h00, shown};
    assign left_img  = {shown, 6'h00};

    // immediate adjust
    // the adjust bit is read live every cycle; the flopped outputs add one
    // cycle, the least that registered outputs allow
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            result_low_byte_out  <= 8'h00;
            result_high_byte_out <= 8'h00;
        end else if (left_adjust_select_in) begin
            result_low_byte_out  <= left_img[7:0];
            result_high_byte_out <= left_img[15:8];
        end else begin
            result_low_byte_out  <= right_img[7:0];
            result_high_byte_out <= right_img[15:8];
        end
    end

    // sign bit
    // top result bit whatever the adjust; only bipolar results give it a
    // meaning, software ignores it otherwise
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            result_sign_bit_out <= 1'b0;
        end else begin
            result_sign_bit_out <= shown[`SIGN_BIT];
        end
    end

    // ==========================================================
    // gain and form report

    // gain from code
    // single-ended inputs bypass the amplifier, reported as unity
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            gain_out <= 5'h00;
        end else if (!is_diff) begin
            gain_out <= `GAIN_UNITY;
        end else if (gain_high) begin
            gain_out <= `GAIN_HIGH;
        end else begin
            gain_out <= `GAIN_LOW;
        end
    end

    // form in use, follows the live selection
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            mode_out <= 2'h0;
        end else begin
            mode_out <= mode;
        end
    end

    // ==========================================================
    // signature row read
    logic       sig_pend;  // request taken, memory read under way
    logic [2:0] sig_addr;  // address held from the request

    // the address is held from the request edge, so a requester that moves
    // its address on early cannot change which byte comes back
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sig_addr <= 3'h0;
        end else if (sig_read_in) begin
            sig_addr <= sig_addr_in;
        end
    end

    // calibration row
    // read data stands until the next request moves the held address
    sig_row_mem u_sig (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .addr_in  (sig_addr),
        .data_out (sig_data_out)
    );

    // request marker, one cycle behind the request
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sig_pend <= 1'b0;
        end else begin
            sig_pend <= sig_read_in;
        end
    end

    // one-cycle strobe alongside the byte; it trails the request by the
    // memory's registered read, so data and strobe share one edge
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sig_valid_out <= 1'b0;
        end else begin
            sig_valid_out <= sig_pend;
        end
    end
endmodule : adc_result_fmt

// >>> logic/adc_fmt_cfg.svh
// constants for the converter result formatter
`ifndef ADC_FMT_CFG_SVH
`define ADC_FMT_CFG_SVH
`define RAW_W          10
`define CODE_MAX       10'h3FF
`define CODE_ZERO      10'h000
`define BIP_MIN        10'h200
`define BIP_MAX        10'h1FF
`define GAIN_LOW       5'h08
`define GAIN_HIGH      5'h14
`define DIFF_BIT       4
`define GAIN_SEL_BIT   0
`define SIGN_BIT       9
`define GAIN_UNITY     5'h01
`define TEMP_CHANNEL   5'h0B
`define SIG_GAIN_ADDR  3'h5
`define SIG_OFFS_ADDR  3'h3
`define SIG_DEPTH      8
`define CAL_GAIN_DEF   8'h80
`define CAL_OFFS_DEF   8'h00
`endif

// >>> logic/adc_fmt_pkg.sv
// types shared by the converter result formatter
package adc_fmt_pkg;
    typedef struct packed {
        logic       valid;   // conversion finished this cycle
        logic [9:0] diff;    // core code, two's complement when signed
        logic       neg;     // core saw negative difference
    } core_result_t;
    typedef enum logic [1:0] {SINGLE, UNIPOLAR, BIPOLAR} conv_mode_t;
endpackage : adc_fmt_pkg

// >>> logic/sig_row_mem.sv
// small signature row holding factory calibration bytes
`include "adc_fmt_cfg.svh"
module sig_row_mem (
    input  wire logic       clk_in,   // system clock
    input  wire logic       rstn_in,  // synchronous reset, active low
    input  wire logic [2:0] addr_in,  // byte address
    output logic      [7:0] data_out  // registered read data
);
    logic [7:0] rom [`SIG_DEPTH];
    // fixed contents: calibration bytes at their two addresses, rest zero
    for (genvar i = 0; i < `SIG_DEPTH; i++) begin : g_row
        if (i == `SIG_GAIN_ADDR) begin : g_gain
            assign rom[i] = `CAL_GAIN_DEF;
        end else if (i == `SIG_OFFS_ADDR) begin : g_offs
            assign rom[i] = `CAL_OFFS_DEF;
        end else begin : g_zero
            assign rom[i] = 8'h00;
        end
    end
    // registered read port
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            data_out <= 8'h00;
        end else begin
            data_out <= rom[addr_in];
        end
    end
endmodule : sig_row_mem

// >>> test/adc_core_model.sv
// converter core stand-in: returns a code a few cycles after a start
module adc_core_model #(
    parameter int LAT = 2  // cycles from start to result
) (
    input  wire logic        clk_in,   // system clock
    input  wire logic        start_in, // begin a conversion
    input  wire logic [10:0] smp_in,   // {neg, code} to hand back
    output adc_fmt_pkg::core_result_t core_out = '0 // result pulse
);
    int cnt = 0;
    // ==========
    // conversion
    // code is only meaningful with valid; it flips otherwise so stale
    // values never pass for a result
    always @(posedge clk_in) begin
        if (start_in) cnt <= LAT;
        else if (cnt != 0) cnt <= cnt - 1;
        core_out.valid <= (cnt == 1);
        core_out.diff  <= (cnt == 1) ? smp_in[9:0] : ~core_out.diff;
        core_out.neg   <= (cnt == 1) ? smp_in[10] : ~core_out.neg;
    end
endmodule : adc_core_model

// >>> test/adc_result_fmt_props.sv
// port assertions for the result formatter
module adc_result_fmt_props (
    input wire logic                      clk_in,
    input wire logic                      rstn_in,
    input wire adc_fmt_pkg::core_result_t core_in,
    input wire logic [4:0]                channel_select_field_in,
    input wire logic                      bipolar_input_select_in,
    input wire logic                      left_adjust_select_in,
    input wire logic                      done_clear_in,
    input wire logic                      sig_read_in,
    input wire logic [7:0]                result_low_byte_out,
    input wire logic [7:0]                result_high_byte_out,
    input wire logic                      conversion_done_flag_out,
    input wire logic                      result_sign_bit_out,
    input wire logic                      sig_valid_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // ==========
    // checks
    sequence sig_answer;
        ##2 sig_valid_out;
    endsequence
    AST_DONE_SET: assert property (core_in.valid |=> conversion_done_flag_out)
        else $error("done flag missing");
    AST_DONE_HOLD: assert property (conversion_done_flag_out && !done_clear_in
        |=> conversion_done_flag_out) else $error("done flag dropped");
    AST_DONE_CLR: assert property (done_clear_in && !core_in.valid
        |=> !conversion_done_flag_out) else $error("done flag kept");
    AST_SINGLE: assert property (core_in.valid && !channel_select_field_in[4]
        && !left_adjust_select_in |=> {result_high_byte_out, result_low_byte_out}
        == {6'h00, $past(core_in.diff)}) else $error("single code wrong");
    AST_SATURATE: assert property (core_in.valid && channel_select_field_in[4]
        && !bipolar_input_select_in && core_in.neg
        |=> {result_high_byte_out, result_low_byte_out} == 16'h0000)
        else $error("no saturation");
    AST_SIGN: assert property (core_in.valid && channel_select_field_in[4]
        && bipolar_input_select_in |=> result_sign_bit_out == $past(core_in.diff[9]))
        else $error("sign bit wrong");
    AST_LEFT: assert property (left_adjust_select_in && !core_in.valid
        |=> result_low_byte_out[5:0] == 6'h00) else $error("left adjust wrong");
    AST_RIGHT: assert property (!left_adjust_select_in && !core_in.valid
        |=> result_high_byte_out[7:2] == 6'h00) else $error("right adjust wrong");
    AST_SIG: assert property (sig_read_in |-> sig_answer)
        else $error("signature byte late");
endmodule : adc_result_fmt_props

// >>> test/adc_result_fmt_test.sv
// bench for the converter result formatter
`include "adc_fmt_cfg.svh"
module adc_result_fmt_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, rstn_in = 0, bip = 0, left = 0, clr = 0, rd = 0, start = 0;
    logic [4:0] ch = 0, gain;
    logic [2:0] addr = 0;
    logic [1:0] mode;
    logic [10:0] smp = 0;
    logic [7:0] lo, hi, sd, offs, gn;
    logic done, sgn, sv;
    adc_fmt_pkg::core_result_t core;
    int fails = 0, checks_done = 0, cyc = 0, t;
    adc_core_model #(.LAT(2)) core_m (.clk_in(clk_in), .start_in(start), .smp_in(smp),
        .core_out(core));
    adc_result_fmt dut (.clk_in(clk_in), .rstn_in(rstn_in), .core_in(core),
        .channel_select_field_in(ch), .bipolar_input_select_in(bip),
        .left_adjust_select_in(left), .done_clear_in(clr), .sig_read_in(rd),
        .sig_addr_in(addr), .result_low_byte_out(lo), .result_high_byte_out(hi),
        .conversion_done_flag_out(done), .result_sign_bit_out(sgn), .gain_out(gain),
        .mode_out(mode), .sig_data_out(sd), .sig_valid_out(sv));
    // ==========
    // tasks
    task wrap_up;
        if (fails == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // one conversion: clear done, start core, wait for the flag
    task conv(input logic [4:0] c, input logic b, input logic l, input logic [10:0] s);
        logic [9:0] k;
        k = (c[4] && !b && s[10]) ? 10'h000 : s[9:0];
        @(posedge clk_in);
        {ch, bip, left, smp, clr, start} <= {c, b, l, s, 2'h3};
        @(posedge clk_in);
        {clr, start} <= 2'h0;
        repeat (10) begin
            @(posedge clk_in);
            #1;
            if (done === 1'b1) break;
        end
        chk("done set", 16'h0001, 16'(done));
        chk("bytes", l ? {k, 6'h00} : {6'h00, k}, {hi, lo});
        chk("sign", 16'(k[9]), 16'(sgn));
        chk("gain", c[4] ? (c[0] ? 16'h0014 : 16'h0008) : 16'h0001, 16'(gain));
        chk("mode", !c[4] ? 16'h0000 : (b ? 16'h0002 : 16'h0001), 16'(mode));
    endtask : conv
    task sig(input logic [2:0] a, input logic [7:0] e, output logic [7:0] v);
        @(posedge clk_in);
        {rd, addr} <= {1'b1, a};
        @(posedge clk_in);
        rd <= 1'b0;
        @(posedge clk_in);
        #1;
        chk("sig", {8'h01, e}, {7'h00, sv, sd});
        v = sd;
    endtask : sig
    // ==========
    // clock, hang guard, sequence
    initial forever #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        repeat (3) @(posedge clk_in);
        rstn_in <= 1'b1;
        conv(5'h0B, 0, 0, 11'h3FF);
        conv(5'h0E, 0, 0, 11'h000);
        conv(5'h10, 0, 0, 11'h555);
        conv(5'h11, 0, 1, 11'h2AA);
        conv(5'h11, 1, 0, 11'h200);
        conv(5'h10, 1, 0, 11'h1FF);
        @(posedge clk_in);
        left <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        chk("adjust", 16'h7FC0, {hi, lo});
        @(posedge clk_in);
        clr <= 1'b1;
        @(posedge clk_in);
        clr <= 1'b0;
        #1;
        chk("done", 16'h0000, 16'(done));
        sig(`SIG_OFFS_ADDR, `CAL_OFFS_DEF, offs);
        sig(`SIG_GAIN_ADDR, `CAL_GAIN_DEF, gn);
        // temperature read: a sensor code of 298 with the row's calibration is 25 degrees
        conv(`TEMP_CHANNEL, 0, 0, 11'h12A);
        t = (int'({hi[1:0], lo}) - (298 - int'($signed(offs)))) * 128 / int'(gn) + 25;
        chk("temperature", 16'h0019, 16'(t));
        wrap_up();
    end
endmodule : adc_result_fmt_test
bind adc_result_fmt adc_result_fmt_props props (.*);
